// File: design/general_dma.sv
// Six-channel general_dma engine: registers, request capture, arbiter, mover
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module general_dma (
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [31:0] o_reg_rdata,
   output logic             o_bus_req,
   output logic             o_bus_write,
   output logic      [31:0] o_bus_addr,
   output logic      [1:0]  o_bus_size,
   output logic      [31:0] o_bus_wdata,
   input  wire logic        i_bus_ack,
   input  wire logic [31:0] i_bus_rdata,
   input  wire logic [3:0]  i_ext_dma_request,
   output logic      [3:0]  o_ext_dma_acknowledge,
   input  wire logic [1:0]  i_stx_req,
   input  wire logic [1:0]  i_srx_req,
   output logic      [1:0]  o_serial_done,
   input  wire logic        i_cin_req,
   input  wire logic        i_cout_req,
   output logic             o_cipher_done,
   output logic      [5:0]  o_chan_pending
);
   localparam int NCH = dma_pkg::NCH;
   localparam int CW = dma_pkg::CNT_W;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'b000_0001,
      ST_RISSUE = 7'b000_0010,
      ST_READ   = 7'b000_0100,
      ST_WPREP  = 7'b000_1000,
      ST_WISSUE = 7'b001_0000,
      ST_WRITE  = 7'b010_0000,
      ST_GAP    = 7'b100_0000
   } state_t;

   logic [16:0]   ctrl_q [NCH];
   logic [31:0]   src_q  [NCH];
   logic [31:0]   dst_q  [NCH];
   logic [CW-1:0] cnt_q  [NCH];
   logic [NCH-1:0] pend_q;
   logic [NCH-1:0] blk_q;
   logic [31:0]   rdata_q;
   state_t        state_q;
   logic [2:0]    cur_q;
   logic [2:0]    units_q;
   logic [1:0]    idx_q;
   logic          bus_req_q;
   logic          bus_write_q;
   logic [31:0]   bus_addr_q;
   logic [1:0]    bus_size_q;
   logic [31:0]   bus_wdata_q;
   logic [1:0]    serial_done_q;
   logic          cipher_done_q;
   logic [3:0]    ack_w;
   logic [3:0]    ack_start;
   logic [31:0]   buf_rdata;

   // Unit size in bytes
   function automatic logic [2:0] size_bytes(input logic [1:0] s);
      case (s)
         dma_pkg::SZ_BYTE: size_bytes = 3'h1;
         dma_pkg::SZ_HALF: size_bytes = 3'h2;
         default:          size_bytes = 3'h4;
      endcase
   endfunction : size_bytes

   // Next address for one unit step
   function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] d, input logic [2:0] n);
      case (d)
         dma_pkg::DIR_INC: step = a + {29'h0, n};
         dma_pkg::DIR_DEC: step = a - {29'h0, n};
         default:          step = a;
      endcase
   endfunction : step

   // External request line that a channel listens to
   function automatic logic [1:0] ext_line(input int c);
      ext_line = (c >= 4) ? 2'(c - 4) : 2'(c);
   endfunction : ext_line

   // Register bus decode
   logic [2:0] rch;
   logic [2:0] rreg;
   logic       rhit;
   assign rch  = i_reg_addr[7:5];
   assign rreg = i_reg_addr[4:2];
   assign rhit = (rch < 3'(NCH)) && (i_reg_addr[1:0] == 2'h0);

   // Current channel view
   logic [2:0]    cmode;
   logic [2:0]    csz;
   logic          cport;
   logic [31:0]   csrc;
   logic [31:0]   cdst;
   logic [CW-1:0] cnt_dec;
   logic          rd_done;
   logic          wr_done;
   logic          grp_end;
   logic          fin;
   assign cmode = ctrl_q[cur_q][3:1];
   assign csz   = size_bytes(ctrl_q[cur_q][7:6]);
   assign cport = (cur_q >= 3'h3);
   assign cnt_dec = (cnt_q[cur_q] > CW'(csz)) ? cnt_q[cur_q] - CW'(csz) : '0;
   assign rd_done = (state_q == ST_READ) && i_bus_ack;
   assign wr_done = (state_q == ST_WRITE) && i_bus_ack;
   assign fin     = wr_done && (cnt_dec == '0);
   assign grp_end = wr_done && ((idx_q == 2'(units_q - 3'h1)) || fin);

   // Peripheral side replaces the ignored address register
   always_comb
   begin
      csrc = src_q[cur_q];
      cdst = dst_q[cur_q];
      case (cmode)
         dma_pkg::MODE_SRX:  csrc = cport ? dma_pkg::SRX1_ADDR : dma_pkg::SRX0_ADDR;
         dma_pkg::MODE_COUT: csrc = dma_pkg::COUT_ADDR;
         dma_pkg::MODE_STX:  cdst = cport ? dma_pkg::STX1_ADDR : dma_pkg::STX0_ADDR;
         dma_pkg::MODE_CIN:  cdst = dma_pkg::CIN_ADDR;
         default:            csrc = src_q[cur_q];
      endcase
   end

   // Request qualification and lowest-number-first selection
   logic [NCH-1:0] elig;
   logic [2:0]     sel;
   logic           take;
   logic [2:0]     want;
   logic [5:0]     want_bytes;
   logic [2:0]     sel_units;
   always_comb
   begin
      logic r;
      logic [2:0] m;
      r = 1'b0;
      m = 3'h0;
      elig = '0;
      for (int c = 0; c < NCH; c++)
      begin
         m = ctrl_q[c][3:1];
         case (m)
            dma_pkg::MODE_SW:   r = 1'b1;
            // Ack high masks the line, so repeat pulses count once
            dma_pkg::MODE_EXT:  r = blk_q[c] | (i_ext_dma_request[ext_line(c)] & ~ack_w[ext_line(c)]);
            dma_pkg::MODE_STX:  r = i_stx_req[c >= 3];
            dma_pkg::MODE_SRX:  r = i_srx_req[c >= 3];
            dma_pkg::MODE_CIN:  r = i_cin_req;
            dma_pkg::MODE_COUT: r = i_cout_req;
            default:            r = 1'b0;
         endcase
         elig[c] = ctrl_q[c][dma_pkg::CTL_RUN] && (cnt_q[c] != '0) && r;
      end
      sel = 3'h0;
      for (int c = NCH - 1; c >= 0; c--)
         if (elig[c])
            sel = 3'(c);
      take = (state_q == ST_IDLE) && (elig != '0);
      m = ctrl_q[sel][3:1];
      if (m == dma_pkg::MODE_CIN || m == dma_pkg::MODE_COUT)
         want = ctrl_q[sel][dma_pkg::CTL_BST] ? dma_pkg::UNITS_BURST : dma_pkg::UNITS_PAIR;
      else if (m == dma_pkg::MODE_STX || m == dma_pkg::MODE_SRX)
         want = dma_pkg::UNITS_ONE;
      else
         want = ctrl_q[sel][dma_pkg::CTL_BST] ? dma_pkg::UNITS_BURST : dma_pkg::UNITS_ONE;
      want_bytes = 6'(want) * 6'(size_bytes(ctrl_q[sel][7:6]));
      // Short remainder goes one unit at a time
      sel_units = (cnt_q[sel] < CW'(want_bytes)) ? dma_pkg::UNITS_ONE : want;
   end

   // Control registers: software writes, hardware clears run at the end
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         for (int c = 0; c < NCH; c++)
            ctrl_q[c] <= dma_pkg::CTL_RST;
      end
      else if (i_reg_wr && rhit && rreg == dma_pkg::REG_CTRL)
         ctrl_q[rch] <= i_reg_wdata[16:0];
      else if (i_reg_wr && rhit && rreg == dma_pkg::REG_RUN)
         ctrl_q[rch][dma_pkg::CTL_RUN] <= i_reg_wdata[0];
      else if (fin)
         ctrl_q[cur_q][dma_pkg::CTL_RUN] <= 1'b0;
   end

   // Source addresses step after every read, except in MODE_SRX and MODE_COUT
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         for (int c = 0; c < NCH; c++)
            src_q[c] <= dma_pkg::ADDR_RST;
      end
      else if (i_reg_wr && rhit && rreg == dma_pkg::REG_SRC)
         src_q[rch] <= i_reg_wdata;
      else if (rd_done && cmode != dma_pkg::MODE_SRX && cmode != dma_pkg::MODE_COUT)
         src_q[cur_q] <= step(src_q[cur_q], ctrl_q[cur_q][9:8], csz);
   end

   // Destination addresses step after every write, except in MODE_STX and MODE_CIN
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         for (int c = 0; c < NCH; c++)
            dst_q[c] <= dma_pkg::ADDR_RST;
      end
      else if (i_reg_wr && rhit && rreg == dma_pkg::REG_DST)
         dst_q[rch] <= i_reg_wdata;
      else if (wr_done && cmode != dma_pkg::MODE_STX && cmode != dma_pkg::MODE_CIN)
         dst_q[cur_q] <= step(dst_q[cur_q], ctrl_q[cur_q][11:10], csz);
   end

   // Transfer counts fall by one unit per write
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         for (int c = 0; c < NCH; c++)
            cnt_q[c] <= dma_pkg::CNT_RST;
      end
      else if (i_reg_wr && rhit && rreg == dma_pkg::REG_CNT)
         cnt_q[rch] <= i_reg_wdata[CW-1:0];
      else if (wr_done)
         cnt_q[cur_q] <= cnt_dec;
   end

   // Pending flags: completion set wins over a same-cycle write-one clear
   always_ff @(posedge i_mclk)
   begin
      logic [NCH-1:0] clr;
      logic [NCH-1:0] set;
      clr = '0;
      set = '0;
      if (i_reg_wr && rhit && rreg == dma_pkg::REG_PEND && i_reg_wdata[0])
         clr[rch] = 1'b1;
      if (fin && ctrl_q[cur_q][dma_pkg::CTL_IE])
         set[cur_q] = 1'b1;
      if (i_sys_rst)
         pend_q <= '0;
      else
         pend_q <= (pend_q & ~clr) | set;
   end

   // Block latch: one request carries the channel to zero count
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         blk_q <= '0;
      else
      begin
         for (int c = 0; c < NCH; c++)
            if (!ctrl_q[c][dma_pkg::CTL_RUN])
               blk_q[c] <= 1'b0;
         if (take && ctrl_q[sel][dma_pkg::CTL_BLK] && ctrl_q[sel][3:1] == dma_pkg::MODE_EXT)
            blk_q[sel] <= 1'b1;
         if (fin)
            blk_q[cur_q] <= 1'b0;
      end
   end

   // Register read data, valid the cycle after the strobe only
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst || !i_reg_rd || !rhit)
         rdata_q <= 32'h0000_0000;
      else
      begin
         case (rreg)
            dma_pkg::REG_CTRL: rdata_q <= {ctrl_q[rch][dma_pkg::CTL_RUN], 14'h0000, ctrl_q[rch]};
            dma_pkg::REG_SRC:  rdata_q <= src_q[rch];
            dma_pkg::REG_DST:  rdata_q <= dst_q[rch];
            dma_pkg::REG_CNT:  rdata_q <= {8'h00, cnt_q[rch]};
            dma_pkg::REG_PEND: rdata_q <= {31'h0000_0000, pend_q[rch]};
            default:           rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Transfer sequencer and bus master outputs
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         state_q       <= ST_IDLE;
         cur_q         <= 3'h0;
         units_q       <= dma_pkg::UNITS_ONE;
         idx_q         <= 2'h0;
         bus_req_q     <= 1'b0;
         bus_write_q   <= 1'b0;
         bus_addr_q    <= 32'h0000_0000;
         bus_size_q    <= 2'h0;
         bus_wdata_q   <= 32'h0000_0000;
         serial_done_q <= 2'h0;
         cipher_done_q <= 1'b0;
      end
      else
      begin
         serial_done_q <= 2'h0;
         cipher_done_q <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               if (take)
               begin
                  cur_q   <= sel;
                  units_q <= sel_units;
                  idx_q   <= 2'h0;
                  state_q <= ST_RISSUE;
               end
            end
            ST_RISSUE:
            begin
               bus_req_q   <= 1'b1;
               bus_write_q <= 1'b0;
               bus_addr_q  <= csrc;
               bus_size_q  <= ctrl_q[cur_q][7:6];
               state_q     <= ST_READ;
            end
            ST_READ:
            begin
               if (i_bus_ack)
               begin
                  bus_req_q <= 1'b0;
                  // All reads of a burst come before any write
                  if (idx_q == 2'(units_q - 3'h1))
                  begin
                     idx_q   <= 2'h0;
                     state_q <= ST_WPREP;
                  end
                  else
                  begin
                     idx_q   <= idx_q + 2'h1;
                     state_q <= ST_RISSUE;
                  end
               end
            end
            ST_WPREP:
               state_q <= ST_WISSUE;
            ST_WISSUE:
            begin
               bus_req_q   <= 1'b1;
               bus_write_q <= 1'b1;
               bus_addr_q  <= cdst;
               bus_wdata_q <= buf_rdata;
               state_q     <= ST_WRITE;
            end
            ST_WRITE:
            begin
               if (i_bus_ack)
               begin
                  bus_req_q <= 1'b0;
                  if (grp_end)
                  begin
                     if (cmode == dma_pkg::MODE_STX || cmode == dma_pkg::MODE_SRX)
                        serial_done_q[cport] <= 1'b1;
                     if (cmode == dma_pkg::MODE_CIN || cmode == dma_pkg::MODE_COUT)
                        cipher_done_q <= 1'b1;
                     state_q <= ST_GAP;
                  end
                  else
                  begin
                     idx_q   <= idx_q + 2'h1;
                     state_q <= ST_WPREP;
                  end
               end
            end
            // Lets requesters drop a served request before it is sampled again
            ST_GAP:
               state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   dma_burst_buf #(
      .DW    (32),
      .DEPTH (4),
      .IW    (2)
   ) u_buf (
      .i_mclk  (i_mclk),
      .i_we    (rd_done),
      .i_waddr (idx_q),
      .i_wdata (i_bus_rdata),
      .i_raddr (idx_q),
      .o_rdata (buf_rdata)
   );

   // Acknowledge starts when a request is taken, not for block continuation
   genvar gl;
   generate
      for (gl = 0; gl < 4; gl++)
      begin : g_ack
         assign ack_start[gl] = take && ctrl_q[sel][3:1] == dma_pkg::MODE_EXT && !blk_q[sel]
                                && ext_line(int'(sel)) == 2'(gl);
         dma_ack_stretch #(
            .LW (4)
         ) u_ack (
            .i_mclk    (i_mclk),
            .i_sys_rst (i_sys_rst),
            .i_start   (ack_start[gl]),
            .i_len     (ctrl_q[sel][16:13]),
            .o_ack     (ack_w[gl])
         );
      end
   endgenerate

   assign o_reg_rdata           = rdata_q;
   assign o_bus_req             = bus_req_q;
   assign o_bus_write           = bus_write_q;
   assign o_bus_addr            = bus_addr_q;
   assign o_bus_size            = bus_size_q;
   assign o_bus_wdata           = bus_wdata_q;
   assign o_ext_dma_acknowledge = ack_w;
   assign o_serial_done         = serial_done_q;
   assign o_cipher_done         = cipher_done_q;
   assign o_chan_pending        = pend_q;
endmodule : general_dma

// File: design/dma_pkg.sv
// Constants shared by the six-channel general_dma engine and its helpers
package dma_pkg;
   localparam int NCH = 6;
   localparam int CNT_W = 24;
   // Register index inside a channel window (byte address bits [4:2])
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_SRC  = 3'h1;
   localparam logic [2:0] REG_DST  = 3'h2;
   localparam logic [2:0] REG_CNT  = 3'h3;
   localparam logic [2:0] REG_RUN  = 3'h4;
   localparam logic [2:0] REG_PEND = 3'h5;
   // Control field positions
   localparam int CTL_RUN  = 0;
   localparam int CTL_MODE = 1;
   localparam int CTL_BLK  = 4;
   localparam int CTL_BST  = 5;
   localparam int CTL_SIZE = 6;
   localparam int CTL_SD   = 8;
   localparam int CTL_DD   = 10;
   localparam int CTL_IE   = 12;
   localparam int CTL_ACK  = 13;
   localparam logic [16:0] CTL_RST = 17'h0_0000;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
   // Modes
   localparam logic [2:0] MODE_SW   = 3'h0;
   localparam logic [2:0] MODE_EXT  = 3'h1;
   localparam logic [2:0] MODE_STX  = 3'h2;
   localparam logic [2:0] MODE_SRX  = 3'h3;
   localparam logic [2:0] MODE_CIN  = 3'h4;
   localparam logic [2:0] MODE_COUT = 3'h5;
   // Direction and unit size codes
   localparam logic [1:0] DIR_INC = 2'h0;
   localparam logic [1:0] DIR_DEC = 2'h1;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   // Units per request
   localparam logic [2:0] UNITS_ONE   = 3'h1;
   localparam logic [2:0] UNITS_PAIR  = 3'h2;
   localparam logic [2:0] UNITS_BURST = 3'h4;
   // Peripheral FIFO addresses on the system bus
   localparam logic [31:0] STX0_ADDR = 32'hf00a_0000;
   localparam logic [31:0] SRX0_ADDR = 32'hf00a_0004;
   localparam logic [31:0] STX1_ADDR = 32'hf00b_0000;
   localparam logic [31:0] SRX1_ADDR = 32'hf00b_0004;
   localparam logic [31:0] CIN_ADDR  = 32'hf00c_0000;
   localparam logic [31:0] COUT_ADDR = 32'hf00c_0004;
endpackage : dma_pkg

// File: design/dma_ack_stretch.sv
// Acknowledge pulse stretcher for one external request line
`timescale 1ns/1ps
module dma_ack_stretch #(
   parameter int LW = 4
) (
   input  wire logic          i_mclk,
   input  wire logic          i_sys_rst,
   input  wire logic          i_start,
   input  wire logic [LW-1:0] i_len,
   output logic               o_ack
);
   logic [LW-1:0] left_q;
   logic          ack_q;

   // Held for i_len + 1 cycles, so code 0 gives one cycle
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         ack_q  <= 1'b0;
         left_q <= '0;
      end
      else if (i_start)
      begin
         ack_q  <= 1'b1;
         left_q <= i_len;
      end
      else if (ack_q)
      begin
         if (left_q == '0)
            ack_q <= 1'b0;
         else
            left_q <= left_q - 1'b1;
      end
   end

   assign o_ack = ack_q;
endmodule : dma_ack_stretch

// File: design/dma_burst_buf.sv
// Small staging memory holding one burst between reads and writes
`timescale 1ns/1ps
module dma_burst_buf #(
   parameter int DW = 32,
   parameter int DEPTH = 4,
   parameter int IW = 2
) (
   input  wire logic          i_mclk,
   input  wire logic          i_we,
   input  wire logic [IW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic [IW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);
   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rdata_q;

   // Read data registered: callers present the address one cycle early
   always_ff @(posedge i_mclk)
   begin
      if (i_we)
         mem_q[i_waddr] <= i_wdata;
      rdata_q <= mem_q[i_raddr];
   end

   assign o_rdata = rdata_q;
endmodule : dma_burst_buf

// File: verif/dma_mem_model.sv
// System bus memory model for the general_dma bench
`timescale 1ns/1ps
module dma_mem_model (
   input  wire logic        i_mclk,
   input  wire logic        i_req,
   input  wire logic        i_write,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic [1:0]  i_wait,
   output logic             o_ack = 1'b0,
   output logic      [31:0] o_rdata = 32'h0,
   output logic      [7:0]  o_wcnt = 8'h0,
   output logic      [31:0] o_waddr = 32'h0,
   output logic      [31:0] o_wdata = 32'h0
);
   logic [1:0] wt_q = 2'h0;
   // Answer after i_wait idle cycles; read data toggles outside an answer
   always_ff @(posedge i_mclk)
   begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack)
      begin
         wt_q <= wt_q + 2'h1;
         if (wt_q >= i_wait)
         begin
            wt_q <= 2'h0;
            o_ack <= 1'b1;
            o_rdata <= i_addr ^ 32'h0f0f_0f0f;
            if (i_write)
            begin
               o_wcnt <= o_wcnt + 8'h1;
               o_waddr <= i_addr;
               o_wdata <= i_wdata;
            end
         end
      end
   end
endmodule : dma_mem_model

// File: verif/general_dma_asserts.sv
// Port-level checker for the general_dma engine
`timescale 1ns/1ps
module general_dma_asserts (
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        o_bus_req,
   input wire logic [31:0] o_bus_addr,
   input wire logic [1:0]  o_bus_size,
   input wire logic [31:0] o_bus_wdata,
   input wire logic        i_bus_ack,
   input wire logic [3:0]  i_ext_dma_request,
   input wire logic [3:0]  o_ext_dma_acknowledge,
   input wire logic [1:0]  o_serial_done,
   input wire logic [5:0]  o_chan_pending
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   logic [3:0] len_q;
   logic [4:0] hi_q;
   logic [2:0] age_q;
   // Ack length of line 0 tracks channel 0 control; only ch0 uses line 0 here
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         len_q <= 4'h0;
      else if (i_reg_wr && i_reg_addr == 8'h00)
         len_q <= i_reg_wdata[16:13];
   end
   // Cycles line 0 ack has stood high
   always_ff @(posedge i_mclk)
   begin
      hi_q <= (i_sys_rst || !o_ext_dma_acknowledge[0]) ? 5'h0 : hi_q + 5'h1;
   end
   // Cycles since the last bus answer, saturating
   always_ff @(posedge i_mclk)
   begin
      age_q <= (i_sys_rst || i_bus_ack) ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
   end
   property p_rd_zero;
      !$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
   property p_req_hold;
      o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_wdata);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("bus request moved");
   property p_req_drop;
      o_bus_req && i_bus_ack |=> !o_bus_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("bus request kept");
   property p_ack_len;
      $fell(o_ext_dma_acknowledge[0]) |-> hi_q == {1'b0, len_q} + 5'h1;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
   property p_ack_cause;
      (o_ext_dma_acknowledge & ~$past(o_ext_dma_acknowledge)
       & ~($past(i_ext_dma_request) | $past(i_ext_dma_request, 2))) == 4'h0;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_ser_done;
      o_serial_done != 2'h0 |-> age_q < 3'h3 ##1 o_serial_done == 2'h0;
   endproperty
   a_ser_done: assert property (p_ser_done) else $error("serial done misplaced");
   property p_pend;
      (o_chan_pending & ~$past(o_chan_pending)) != 6'h0 |-> age_q < 3'h5;
   endproperty
   a_pend: assert property (p_pend) else $error("pending without transfer");
   property p_ser_size;
      o_bus_req && o_bus_addr == dma_pkg::STX1_ADDR |-> o_bus_size == dma_pkg::SZ_BYTE;
   endproperty
   a_ser_size: assert property (p_ser_size) else $error("serial unit not byte");
endmodule : general_dma_asserts
bind general_dma general_dma_asserts i_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .o_bus_req(o_bus_req), .o_bus_addr(o_bus_addr), .o_bus_size(o_bus_size),
   .o_bus_wdata(o_bus_wdata), .i_bus_ack(i_bus_ack), .i_ext_dma_request(i_ext_dma_request),
   .o_ext_dma_acknowledge(o_ext_dma_acknowledge), .o_serial_done(o_serial_done),
   .o_chan_pending(o_chan_pending));

// File: verif/tb_top.sv
// Self-checking bench for the general_dma engine
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [1:0] sz; logic [1:0] dir; logic bst; logic [23:0] cnt;
      logic [7:0] n; logic [31:0] ls; logic [31:0] ld;} row_t;
   logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, back, breq, bwr, cdone;
   logic [7:0]  addr = 8'h0, wcnt, w;
   logic [31:0] wdata = 32'h0, rdata, baddr, bwd, brd, waddr, wdat, v;
   logic [1:0]  bsize, sdone, mwait = 2'h0;
   logic [3:0]  eack;
   logic [5:0]  pend;
   logic [6:0]  rq = 7'h0, hs;
   int          num_errors = 0, checks_done = 0, i;
   row_t        rows [4];
   assign hs = {cdone, sdone, eack};
   general_dma i_general_dma (.i_mclk(mclk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_bus_req(breq), .o_bus_write(bwr),
      .o_bus_addr(baddr), .o_bus_size(bsize), .o_bus_wdata(bwd), .i_bus_ack(back), .i_bus_rdata(brd),
      .i_ext_dma_request(rq[3:0]), .o_ext_dma_acknowledge(eack), .i_stx_req(rq[5:4]),
      .i_srx_req(2'h0), .o_serial_done(sdone), .i_cin_req(rq[6]), .i_cout_req(rq[6]),
      .o_cipher_done(cdone), .o_chan_pending(pend));
   dma_mem_model i_dma_mem_model (.i_mclk(mclk), .i_req(breq), .i_write(bwr), .i_addr(baddr),
      .i_wdata(bwd), .i_wait(mwait), .o_ack(back), .o_rdata(brd), .o_wcnt(wcnt), .o_waddr(waddr),
      .o_wdata(wdat));
   // 100 ns clock
   initial
   begin
      forever #50 mclk = ~mclk;
   end
   task close_out;
   begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask : close_out
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
   begin
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch %s exp %h got %h", nm, exp, got);
         num_errors++;
      end
   end
   endtask : chk
   task tmo(input string nm);
   begin
      $display("mismatch timeout %s exp done got none", nm);
      num_errors++;
      close_out();
   end
   endtask : tmo
   task wreg(input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   end
   endtask : wreg
   // Read data stand only in the cycle after the strobe
   task rreg(input logic [7:0] a, output logic [31:0] d);
   begin
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   end
   endtask : rreg
   function automatic logic [31:0] cw(logic [2:0] m, logic b, logic t, logic [1:0] s, logic [1:0] r,
      logic [3:0] k);
      return {15'h0, k, 1'b1, r, r, s, t, b, m, 1'b1};
   endfunction : cw
   task prog(input logic [2:0] ch, input logic [31:0] s, input logic [31:0] d, input logic [23:0] c,
      input logic [31:0] ctl);
   begin
      wreg({ch, 5'h04}, s);
      wreg({ch, 5'h08}, d);
      wreg({ch, 5'h0c}, {8'h0, c});
      wreg({ch, 5'h00}, ctl);
      w = wcnt;
   end
   endtask : prog
   task wait_wr(input logic [7:0] n);
      int k;
   begin
      for (k = 0; k < 400 && wcnt < n; k++)
         @(posedge mclk);
      if (wcnt < n)
         tmo("writes");
   end
   endtask : wait_wr
   // Raise one request line and drop it once its answer is seen
   task fire(input int k);
      int j;
   begin
      rq[k] <= 1'b1;
      for (j = 0; j < 300 && hs[k] !== 1'b1; j++)
         @(posedge mclk);
      rq[k] <= 1'b0;
      @(posedge mclk);
      if (j == 300)
         tmo("handshake");
   end
   endtask : fire
   initial
   begin
      rows[0] = '{2'h0, 2'h0, 1'b0, 24'd3, 8'd3, 32'h102, 32'h202};
      rows[1] = '{2'h1, 2'h1, 1'b0, 24'd4, 8'd2, 32'h0fe, 32'h1fe};
      rows[2] = '{2'h2, 2'h2, 1'b0, 24'd8, 8'd2, 32'h100, 32'h200};
      rows[3] = '{2'h2, 2'h0, 1'b1, 24'd20, 8'd5, 32'h110, 32'h210};
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rreg(8'h0c, v);
      chk("count reset", v, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         mwait <= i[1:0];
         prog(3'h0, 32'h100, 32'h200, rows[i].cnt, cw(3'h0, 1'b0, rows[i].bst, rows[i].sz, rows[i].dir, 4'h0));
         wait_wr(w + rows[i].n);
         repeat (4) @(posedge mclk);
         chk("writes", wcnt, w + rows[i].n);
         chk("last dst", waddr, rows[i].ld);
         chk("data", wdat, rows[i].ls ^ 32'h0f0f_0f0f);
         chk("pending", pend, 6'h01);
         rreg(8'h0c, v);
         chk("count end", v, 32'h0);
         rreg(8'h00, v);
         chk("busy", v[31], 1'b0);
         wreg(8'h14, 32'h1);
         #1 chk("pend clear", pend, 6'h0);
      end
      w = wcnt;
      repeat (20) @(posedge mclk);
      chk("no restart", wcnt, w);
      prog(3'h2, 32'h300, 32'h400, 24'd2, cw(3'h1, 1'b0, 1'b0, 2'h0, 2'h0, 4'h3));
      fire(2);
      wait_wr(w + 8'd1);
      repeat (30) @(posedge mclk);
      chk("single", wcnt, w + 8'd1);
      fire(2);
      wait_wr(w + 8'd2);
      chk("ext dst", waddr, 32'h401);
      prog(3'h0, 32'h700, 32'h800, 24'd3, cw(3'h1, 1'b1, 1'b0, 2'h0, 2'h0, 4'h5));
      fire(0);
      wait_wr(w + 8'd3);
      chk("block dst", waddr, 32'h802);
      prog(3'h3, 32'h500, 32'h0, 24'd2, cw(3'h2, 1'b0, 1'b0, 2'h0, 2'h0, 4'h0));
      fire(5);
      fire(5);
      wait_wr(w + 8'd2);
      chk("serial dst", waddr, dma_pkg::STX1_ADDR);
      chk("serial data", wdat, 32'h501 ^ 32'h0f0f_0f0f);
      prog(3'h5, 32'h0, 32'h600, 24'd8, cw(3'h5, 1'b0, 1'b0, 2'h2, 2'h0, 4'h0));
      fire(6);
      wait_wr(w + 8'd2);
      repeat (4) @(posedge mclk);
      chk("cipher dst", waddr, 32'h604);
      chk("cipher data", wdat, dma_pkg::COUT_ADDR ^ 32'h0f0f_0f0f);
      chk("cipher pend", pend[5], 1'b1);
      prog(3'h1, 32'h900, 32'h0, 24'd8, cw(3'h4, 1'b0, 1'b0, 2'h2, 2'h0, 4'h0));
      fire(6);
      wait_wr(w + 8'd2);
      chk("cipher in dst", waddr, dma_pkg::CIN_ADDR);
      chk("cipher in data", wdat, 32'h904 ^ 32'h0f0f_0f0f);
      rreg(8'hc0, v);
      chk("unmapped", v, 32'h0);
      close_out();
   end
endmodule : tb_top
